/* File: src/dac_mode_pkg.sv */
// constants for the audio dac mode-control register bank
// assumes one 100 mhz system clock and 16-bit control words from the host port
package dac_mode_pkg;

	// ==========================================================
	// control word layout
	localparam int WORD_W = 16;
	localparam int DIR_BIT = 15;
	localparam int IDX_HI = 14;
	localparam int IDX_LO = 8;
	localparam int IDX_W = 7;
	localparam int DATA_W = 8;

	// ==========================================================
	// register indices
	localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
	localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
	localparam logic [6:0] IDX_FORMAT_CTRL = 7'h12;
	localparam logic [6:0] IDX_OUTPUT_CTRL = 7'h13;
	localparam logic [6:0] IDX_SYSTEM_CTRL = 7'h14;

	// ==========================================================
	// field positions, format_deemphasis_mute_control
	localparam int LOAD_EN_BIT = 7;
	localparam int FORMAT_HI = 6;
	localparam int FORMAT_LO = 4;
	localparam int DEEMPH_HI = 3;
	localparam int DEEMPH_LO = 2;
	localparam int DEEMPH_EN_BIT = 1;
	localparam int SOFT_MUTE_BIT = 0;

	// field positions, output_filter_rate_control
	localparam int INVERT_BIT = 7;
	localparam int RATE_HI = 6;
	localparam int RATE_LO = 5;
	localparam int OUT_DIS_BIT = 4;
	localparam int ROLLOFF_BIT = 1;
	localparam int INZ_MUTE_BIT = 0;
	localparam logic [7:0] OUTPUT_CTRL_MASK = 8'hf3;

	// field positions, system_mode_control
	localparam int SYS_RESET_BIT = 6;
	localparam int STREAM_BIT = 5;
	localparam int BYPASS_BIT = 4;
	localparam logic [7:0] SYSTEM_CTRL_MASK = 8'h30;

	// ==========================================================
	// reset values
	localparam logic [7:0] ATTEN_RESET = 8'hff;
	localparam logic [2:0] FORMAT_RESET = 3'h5;
	localparam logic [1:0] DEEMPH_RESET = 2'h0;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// attenuation codes
	localparam logic [7:0] ATTEN_FULL_SCALE = 8'hff;
	localparam logic [7:0] ATTEN_MUTE_TOP = 8'h0e;
	localparam logic [7:0] ATTEN_MUTE_GOAL = 8'h00;
	localparam int STEP_DIV_W = 3;

	// ==========================================================
	// audio format codes
	typedef enum logic [2:0] {
		FORMAT_RJ16 = 3'h0,
		FORMAT_RJ20 = 3'h1,
		FORMAT_RJ24 = 3'h2,
		FORMAT_LJ24 = 3'h3,
		FORMAT_I2S16 = 3'h4,
		FORMAT_I2S24 = 3'h5
	} audio_format_e;

endpackage

/* File: src/atten_ramp.sv */
// one channel attenuator that walks its level one code per step toward a goal
// assumes step_en is a one-cycle pulse derived from the word clock
`timescale 1ns/100ps
module atten_ramp #(
	parameter int CODE_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic soft_clear,
	input wire logic step_en,
	input wire logic [CODE_W-1:0] goal,
	input wire logic [CODE_W-1:0] reset_level,
	output logic [CODE_W-1:0] level
);
	logic [CODE_W-1:0] next_level;
	wire go_down = level > goal;
	wire go_up = level < goal;

	// ==========================================================
	// one code per step keeps transitions click free
	always_comb begin
		next_level = level;
		if (soft_clear) begin
			next_level = reset_level;
		end else if (step_en && go_down) begin
			next_level = level - 1'b1;
		end else if (step_en && go_up) begin
			next_level = level + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			level <= '1;
		end else begin
			level <= next_level;
		end
	end
endmodule // atten_ramp

/* File: src/audio_dac_mode_control_regs.sv */
// mode-control register bank of a stereo audio dac with attenuator ramps
// assumes the serial control port delivers whole 16-bit words as one-cycle
// strobes, and word_clock_tick pulses once per audio frame
`timescale 1ns/100ps

// How it works
// - top word bit picks write or read
// - attenuation half dB times code minus 255
// - codes 0 to 14 mute fully
// - left and right codes set independently
// - load enable gates applying new codes
// - three-bit field picks serial audio format
// - two-bit field picks de-emphasis rate
// - one enable switches de-emphasis both channels
// - soft mute ramps both channels to mute
// - step every 1, 2, 4, 8 frames
// - invert bit flips both output polarities
// - output disable forces bipolar zero
// - rolloff bit picks sharp or slow
// - zero mute holds zero when both silent
// - write-only reset bit gives one pulse
// - stream bit enables one-bit stream interface
// - stream mode reuses rate field for filter
// - bypass bit skips interpolation filter
module audio_dac_mode_control_regs #(
	parameter int CODE_W = dac_mode_pkg::DATA_W
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic [dac_mode_pkg::WORD_W-1:0] cmd_word,
	output logic rd_valid,
	output logic [dac_mode_pkg::DATA_W-1:0] rd_data,
	input wire logic word_clock_tick,
	input wire logic zero_left,
	input wire logic zero_right,
	output logic [CODE_W-1:0] left_atten_code,
	output logic [CODE_W-1:0] right_atten_code,
	output logic [CODE_W-1:0] left_atten_half_db,
	output logic [CODE_W-1:0] right_atten_half_db,
	output logic left_infinite_mute,
	output logic right_infinite_mute,
	output logic [2:0] audio_format_select,
	output logic [1:0] deemph_rate_active,
	output logic deemph_active,
	output logic [1:0] stream_filter_select,
	output logic phase_invert,
	output logic rolloff_select,
	output logic force_bipolar_zero,
	output logic one_bit_stream_mode,
	output logic internal_filter_bypass,
	output logic system_reset_pulse
);
	import dac_mode_pkg::*;

	// ==========================================================
	// register state
	logic [7:0] left_level_reg;
	logic [7:0] right_level_reg;
	logic [CODE_W-1:0] left_goal;
	logic [CODE_W-1:0] right_goal;
	logic atten_load_enable;
	logic [1:0] deemph_rate_select;
	logic deemph_enable;
	logic soft_mute;
	logic [1:0] atten_step_rate;
	logic analog_output_disable;
	logic infinite_zero_mute_enable;
	logic [STEP_DIV_W-1:0] frame_count;
	logic step_en;

	// ==========================================================
	// decode
	wire is_read = cmd_valid && cmd_word[DIR_BIT];
	wire is_write = cmd_valid && !cmd_word[DIR_BIT];
	wire [IDX_W-1:0] idx = cmd_word[IDX_HI:IDX_LO];
	wire [7:0] wdata = cmd_word[DATA_W-1:0];
	wire wr_left = is_write && (idx == IDX_LEFT_ATTEN);
	wire wr_right = is_write && (idx == IDX_RIGHT_ATTEN);
	wire wr_format = is_write && (idx == IDX_FORMAT_CTRL);
	wire wr_output = is_write && (idx == IDX_OUTPUT_CTRL);
	wire wr_system = is_write && (idx == IDX_SYSTEM_CTRL);
	wire soft_reset_req = wr_system && wdata[SYS_RESET_BIT];
	// a write to an unknown index matches no strobe and is dropped

	wire [7:0] format_read = {atten_load_enable, audio_format_select,
		deemph_rate_select, deemph_enable, soft_mute};
	// reserved positions come back as zero
	wire [7:0] output_read = {phase_invert, atten_step_rate,
		analog_output_disable, 2'b00, rolloff_select,
		infinite_zero_mute_enable} & OUTPUT_CTRL_MASK;
	// reset bit is write-only so it never reads back
	wire [7:0] system_read = {2'b00, one_bit_stream_mode,
		internal_filter_bypass, 4'h0} & SYSTEM_CTRL_MASK;

	logic [7:0] read_mux;
	always_comb begin
		case (idx)
			IDX_LEFT_ATTEN: read_mux = left_level_reg;
			IDX_RIGHT_ATTEN: read_mux = right_level_reg;
			IDX_FORMAT_CTRL: read_mux = format_read;
			IDX_OUTPUT_CTRL: read_mux = output_read;
			IDX_SYSTEM_CTRL: read_mux = system_read;
			default: read_mux = UNMAPPED_READ;
		endcase
	end

	// ==========================================================
	// read answer, one cycle after the command
	// rd_data holds between reads so a slow host can fetch it late
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			rd_valid <= is_read;
			if (is_read) begin
				rd_data <= read_mux;
			end
		end
	end

	// ==========================================================
	// level registers and applied goals
	// goals only move while loading is enabled; with it off a write
	// updates the level register that reads back, but not the goal
	// a code staged while loading is off stays staged; raising the
	// enable later does not replay it
	wire left_apply = wr_left && atten_load_enable;
	wire right_apply = wr_right && atten_load_enable;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			left_level_reg <= ATTEN_RESET;
			right_level_reg <= ATTEN_RESET;
			left_goal <= ATTEN_RESET;
			right_goal <= ATTEN_RESET;
		end else if (system_reset_pulse) begin
			left_level_reg <= ATTEN_RESET;
			right_level_reg <= ATTEN_RESET;
			left_goal <= ATTEN_RESET;
			right_goal <= ATTEN_RESET;
		end else begin
			if (wr_left) begin
				left_level_reg <= wdata;
			end
			if (wr_right) begin
				right_level_reg <= wdata;
			end
			if (left_apply) begin
				left_goal <= wdata;
			end
			if (right_apply) begin
				right_goal <= wdata;
			end
		end
	end

	// ==========================================================
	// format, de-emphasis and mute control
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			atten_load_enable <= 1'b0;
			audio_format_select <= FORMAT_RESET;
			deemph_rate_select <= DEEMPH_RESET;
			deemph_enable <= 1'b0;
			soft_mute <= 1'b0;
		end else if (system_reset_pulse) begin
			atten_load_enable <= 1'b0;
			audio_format_select <= FORMAT_RESET;
			deemph_rate_select <= DEEMPH_RESET;
			deemph_enable <= 1'b0;
			soft_mute <= 1'b0;
		end else if (wr_format) begin
			atten_load_enable <= wdata[LOAD_EN_BIT];
			audio_format_select <= wdata[FORMAT_HI:FORMAT_LO];
			deemph_rate_select <= wdata[DEEMPH_HI:DEEMPH_LO];
			deemph_enable <= wdata[DEEMPH_EN_BIT];
			soft_mute <= wdata[SOFT_MUTE_BIT];
		end
	end

	// ==========================================================
	// output, filter and rate control; reserved bits never stored
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_invert <= 1'b0;
			atten_step_rate <= RATE_RESET;
			analog_output_disable <= 1'b0;
			rolloff_select <= 1'b0;
			infinite_zero_mute_enable <= 1'b0;
		end else if (system_reset_pulse) begin
			phase_invert <= 1'b0;
			atten_step_rate <= RATE_RESET;
			analog_output_disable <= 1'b0;
			rolloff_select <= 1'b0;
			infinite_zero_mute_enable <= 1'b0;
		end else if (wr_output) begin
			phase_invert <= wdata[INVERT_BIT];
			atten_step_rate <= wdata[RATE_HI:RATE_LO];
			analog_output_disable <= wdata[OUT_DIS_BIT];
			rolloff_select <= wdata[ROLLOFF_BIT];
			infinite_zero_mute_enable <= wdata[INZ_MUTE_BIT];
		end
	end

	// ==========================================================
	// system mode and the self-clearing reset pulse
	// a reset write also takes no other field of the same word,
	// since the pulse returns everything to defaults next cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			one_bit_stream_mode <= 1'b0;
			internal_filter_bypass <= 1'b0;
			system_reset_pulse <= 1'b0;
		end else begin
			system_reset_pulse <= soft_reset_req;
			if (system_reset_pulse) begin
				one_bit_stream_mode <= 1'b0;
				internal_filter_bypass <= 1'b0;
			end else if (wr_system && !soft_reset_req) begin
				one_bit_stream_mode <= wdata[STREAM_BIT];
				internal_filter_bypass <= wdata[BYPASS_BIT];
			end
		end
	end

	// ==========================================================
	// step divider: frames counted so a step lands every 2^rate frames
	// limitation: the count runs free, so the first step after a rate
	// change may come early; only the reset pulse clears the phase
	// clearing it on the pulse keeps both ramps restarting in step
	wire [STEP_DIV_W-1:0] rate_mask =
		STEP_DIV_W'((1 << atten_step_rate) - 1);
	wire next_step = word_clock_tick &&
		((frame_count & rate_mask) == rate_mask);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_count <= '0;
			step_en <= 1'b0;
		end else begin
			step_en <= next_step;
			if (system_reset_pulse) begin
				frame_count <= '0;
			end else if (word_clock_tick) begin
				frame_count <= frame_count + 1'b1;
			end
		end
	end

	// ==========================================================
	// per-channel ramps
	// soft mute overrides the goal with code 0 and the ramp walks down
	// one code per step, so unmuting returns along the same path
	logic [CODE_W-1:0] goal_set [2];
	logic [CODE_W-1:0] level_set [2];
	logic [CODE_W-1:0] ramp_level [2];
	assign goal_set[0] = left_goal;
	assign goal_set[1] = right_goal;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			wire [CODE_W-1:0] goal = soft_mute ? CODE_W'(ATTEN_MUTE_GOAL)
				: goal_set[ch];
			atten_ramp #(
				.CODE_W(CODE_W)
			) u_ramp (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.soft_clear(system_reset_pulse),
				.step_en(step_en),
				.goal(goal),
				.reset_level(CODE_W'(ATTEN_RESET)),
				.level(ramp_level[ch])
			);
			assign level_set[ch] = ramp_level[ch];
		end
	endgenerate

	// ==========================================================
	// applied attenuation outputs
	wire [CODE_W-1:0] left_now = level_set[0];
	wire [CODE_W-1:0] right_now = level_set[1];
	// depth below full scale in half-dB units
	wire [CODE_W-1:0] left_depth = CODE_W'(ATTEN_FULL_SCALE) - left_now;
	wire [CODE_W-1:0] right_depth = CODE_W'(ATTEN_FULL_SCALE) - right_now;
	// codes at or under the mute top give no finite level
	wire left_mute_now = left_now <= CODE_W'(ATTEN_MUTE_TOP);
	wire right_mute_now = right_now <= CODE_W'(ATTEN_MUTE_TOP);


	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			left_atten_code <= ATTEN_RESET;
			right_atten_code <= ATTEN_RESET;
			left_atten_half_db <= '0;
			right_atten_half_db <= '0;
			left_infinite_mute <= 1'b0;
			right_infinite_mute <= 1'b0;
		end else begin
			left_atten_code <= left_now;
			right_atten_code <= right_now;
			left_atten_half_db <= left_depth;
			right_atten_half_db <= right_depth;
			left_infinite_mute <= left_mute_now;
			right_infinite_mute <= right_mute_now;
		end
	end

	// ==========================================================
	// mode-dependent outputs
	// zero mute is ignored in stream mode, no zero detect there
	// both channels must be silent; one quiet channel never mutes the other
	wire zero_hold = infinite_zero_mute_enable && zero_left &&
		zero_right && !one_bit_stream_mode;
	wire next_force_zero = analog_output_disable || zero_hold;
	wire next_deemph_active = deemph_enable && !one_bit_stream_mode;
	wire [1:0] next_deemph_rate = one_bit_stream_mode ? DEEMPH_RESET
		: deemph_rate_select;
	// in stream mode the rate field drives the analog filter instead
	wire [1:0] next_filter_select = one_bit_stream_mode ?
		deemph_rate_select : DEEMPH_RESET;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			force_bipolar_zero <= 1'b0;
			deemph_rate_active <= DEEMPH_RESET;
			deemph_active <= 1'b0;
			stream_filter_select <= DEEMPH_RESET;
		end else begin
			force_bipolar_zero <= next_force_zero;
			deemph_active <= next_deemph_active;
			deemph_rate_active <= next_deemph_rate;
			stream_filter_select <= next_filter_select;
		end
	end
endmodule // audio_dac_mode_control_regs

/* File: dv/dac_mode_assertions.sv */
// port assertions for the dac mode-control register bank
// assumes a bind onto audio_dac_mode_control_regs, one clock domain
`timescale 1ns/100ps
module dac_mode_assertions #(
	parameter int CODE_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic [dac_mode_pkg::WORD_W-1:0] cmd_word,
	input wire logic rd_valid,
	input wire logic [CODE_W-1:0] left_atten_code,
	input wire logic [CODE_W-1:0] left_atten_half_db,
	input wire logic left_infinite_mute,
	input wire logic [2:0] audio_format_select,
	input wire logic [1:0] deemph_rate_active,
	input wire logic deemph_active,
	input wire logic [1:0] stream_filter_select,
	input wire logic phase_invert,
	input wire logic force_bipolar_zero,
	input wire logic one_bit_stream_mode,
	input wire logic system_reset_pulse
);
	import dac_mode_pkg::*;
	wire logic rd_cmd = cmd_valid && cmd_word[DIR_BIT];
	wire logic wr_cmd = cmd_valid && !cmd_word[DIR_BIT];
	wire logic [6:0] idx = cmd_word[IDX_HI:IDX_LO];
	wire logic reset_cmd = wr_cmd && idx == IDX_SYSTEM_CTRL &&
		cmd_word[SYS_RESET_BIT];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// checks
	a_read_answer: assert property (rd_cmd |=> rd_valid)
		else $error("read not answered");
	a_read_cause: assert property (rd_valid |-> $past(rd_cmd))
		else $error("answer without read");
	a_format_write: assert property (wr_cmd && idx == IDX_FORMAT_CTRL
		|=> audio_format_select == $past(cmd_word[FORMAT_HI:FORMAT_LO]))
		else $error("format not stored");
	a_invert_write: assert property (wr_cmd && idx == IDX_OUTPUT_CTRL
		|=> phase_invert == $past(cmd_word[INVERT_BIT]))
		else $error("invert not stored");
	a_half_db: assert property (left_atten_half_db == ~left_atten_code)
		else $error("half db wrong");
	a_mute_flag: assert property (left_infinite_mute ==
		(left_atten_code <= ATTEN_MUTE_TOP))
		else $error("mute flag wrong");
	a_reset_pulse: assert property (reset_cmd |=>
		system_reset_pulse ##1 !system_reset_pulse)
		else $error("reset pulse not single");
	a_pulse_cause: assert property (system_reset_pulse |->
		$past(reset_cmd))
		else $error("spurious reset pulse");
	a_stream_deemph: assert property (one_bit_stream_mode &&
		$past(one_bit_stream_mode) |-> !deemph_active &&
		deemph_rate_active == 2'h0)
		else $error("deemphasis on in stream mode");
	a_filter_idle: assert property (!one_bit_stream_mode &&
		!$past(one_bit_stream_mode) |-> stream_filter_select == 2'h0)
		else $error("filter select outside stream");
	a_out_disable: assert property (wr_cmd && idx == IDX_OUTPUT_CTRL &&
		cmd_word[OUT_DIS_BIT] |-> ##2 force_bipolar_zero)
		else $error("output not forced to zero");
	c_read: cover property (rd_cmd ##1 rd_valid);
	c_soft_reset: cover property (system_reset_pulse);
	c_mute: cover property ($rose(left_infinite_mute));
endmodule // dac_mode_assertions

/* File: dv/host_port_model.sv */
// host side of the serial control port, one word per access
// assumes the bench calls access() and drives the port nowhere else
`timescale 1ns/100ps
module host_port_model (
	input wire logic sys_clk,
	output logic cmd_valid,
	output logic [15:0] cmd_word,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
	end
	// ==========================================================
	// access
	// idle word is inverted so a stale word never looks current
	task automatic access(input logic [15:0] w, output logic [7:0] d,
		output logic ok);
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_word = w;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		cmd_word = ~w;
		ok = rd_valid;
		d = rd_data;
	endtask
endmodule // host_port_model

/* File: dv/audio_dac_mode_control_regs_test.sv */
// self-checking bench for the dac mode-control register bank
// assumes host_port_model and dac_mode_assertions compiled before
`timescale 1ns/100ps
module audio_dac_mode_control_regs_test;
	import dac_mode_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic word_clock_tick = 1'b0;
	logic zero_left = 1'b0;
	logic zero_right = 1'b0;
	logic cmd_valid, rd_valid, lm, rm, dm, inv, rol, fbz, stream, byp;
	logic rst_pulse;
	logic [15:0] cmd_word;
	logic [7:0] rd_data, lc, rc, lh, rh;
	logic [2:0] af;
	logic [1:0] dr, fs;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	host_port_model host_port_model_inst (.sys_clk, .cmd_valid, .cmd_word,
		.rd_valid, .rd_data);
	audio_dac_mode_control_regs audio_dac_mode_control_regs_inst (.sys_clk,
		.reset_n, .cmd_valid, .cmd_word, .rd_valid, .rd_data,
		.word_clock_tick, .zero_left, .zero_right, .left_atten_code(lc),
		.right_atten_code(rc), .left_atten_half_db(lh),
		.right_atten_half_db(rh), .left_infinite_mute(lm),
		.right_infinite_mute(rm), .audio_format_select(af),
		.deemph_rate_active(dr), .deemph_active(dm),
		.stream_filter_select(fs), .phase_invert(inv),
		.rolloff_select(rol), .force_bipolar_zero(fbz),
		.one_bit_stream_mode(stream), .internal_filter_bypass(byp),
		.system_reset_pulse(rst_pulse));
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] v);
		logic [7:0] d;
		logic ok;
		host_port_model_inst.access({1'b0, idx, v}, d, ok);
	endtask
	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host_port_model_inst.access({1'b1, idx, 8'h00}, d, ok);
		chk(8'(ok), 8'h01);
		chk(d, exp);
	endtask
	// code output trails the tick by three edges
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			word_clock_tick = 1'b1;
			@(negedge sys_clk);
			word_clock_tick = 1'b0;
			repeat (3) @(negedge sys_clk);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		rd(IDX_LEFT_ATTEN, 8'hff);
		rd(IDX_RIGHT_ATTEN, 8'hff);
		rd(IDX_FORMAT_CTRL, 8'h50);
		rd(IDX_OUTPUT_CTRL, 8'h00);
		rd(IDX_SYSTEM_CTRL, 8'h00);
		wr(7'h15, 8'hff);
		rd(7'h15, 8'h00);
		rd(7'h00, 8'h00);
		wr(IDX_OUTPUT_CTRL, 8'hff);
		rd(IDX_OUTPUT_CTRL, 8'hf3);
		chk(8'(inv), 8'h01);
		chk(8'(rol), 8'h01);
		chk(8'(fbz), 8'h01);
		wr(IDX_OUTPUT_CTRL, 8'h01);
		zero_left = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(8'(fbz), 8'h00);
		zero_right = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(8'(fbz), 8'h01);
		wr(IDX_FORMAT_CTRL, 8'h0e);
		wr(IDX_SYSTEM_CTRL, 8'hbf);
		rd(IDX_SYSTEM_CTRL, 8'h30);
		chk({6'h0, stream, byp}, 8'h03);
		chk({4'h0, dr, fs}, 8'h03);
		chk({7'h0, dm | fbz}, 8'h00);
		wr(IDX_SYSTEM_CTRL, 8'h00);
		repeat (2) @(negedge sys_clk);
		chk({3'h0, dm, dr, fs}, 8'h1c);
		for (int i = 0; i < 8; i++) begin
			wr(IDX_FORMAT_CTRL, {1'b0, i[2:0], i[1:0], 2'h0});
			@(negedge sys_clk);
			chk({3'h0, af, dr}, {3'h0, i[2:0], i[1:0]});
		end
		wr(IDX_LEFT_ATTEN, 8'h40);
		ticks(2);
		chk(lc, 8'hff);
		rd(IDX_LEFT_ATTEN, 8'h40);
		wr(IDX_SYSTEM_CTRL, 8'h40);
		chk(8'(rst_pulse), 8'h01);
		@(negedge sys_clk);
		chk(8'(rst_pulse), 8'h00);
		rd(IDX_FORMAT_CTRL, 8'h50);
		rd(IDX_LEFT_ATTEN, 8'hff);
		wr(IDX_OUTPUT_CTRL, 8'h60);
		wr(IDX_FORMAT_CTRL, 8'h80);
		wr(IDX_LEFT_ATTEN, 8'h10);
		wr(IDX_RIGHT_ATTEN, 8'hfe);
		ticks(7);
		chk(lc, 8'hff);
		ticks(1);
		chk(lc, 8'hfe);
		chk(rc, 8'hfe);
		wr(IDX_OUTPUT_CTRL, 8'h00);
		ticks(237);
		chk(lc, 8'h11);
		chk(lh, 8'hee);
		chk({rh[6:0], rm}, 8'h02);
		chk(rc, 8'hfe);
		wr(IDX_LEFT_ATTEN, 8'h0e);
		ticks(2);
		chk({lh[6:0], lm}, 8'he0);
		ticks(1);
		chk({lc[6:0], lm}, 8'h1d);
		wr(IDX_FORMAT_CTRL, 8'h81);
		ticks(14);
		chk(lc, 8'h00);
		chk(rc, 8'hf0);
		wr(IDX_FORMAT_CTRL, 8'h80);
		ticks(1);
		chk(lc, 8'h01);
		finish_test();
	end
endmodule // audio_dac_mode_control_regs_test

bind audio_dac_mode_control_regs dac_mode_assertions #(.CODE_W(CODE_W))
	dac_mode_assertions_inst (.sys_clk, .reset_n, .cmd_valid, .cmd_word,
	.rd_valid, .left_atten_code, .left_atten_half_db, .left_infinite_mute,
	.audio_format_select, .deemph_rate_active, .deemph_active,
	.stream_filter_select, .phase_invert, .force_bipolar_zero,
	.one_bit_stream_mode, .system_reset_pulse);
